// file: rtl/fao_pkg.sv
// package: function codes, widths and reset values for the status-output logic
package fao_pkg;
  // ***********************************************************
  // output function codes
  // ***********************************************************
  localparam logic [5:0] FAO_FN_RUN      = 6'h00;  // 00
  localparam logic [5:0] FAO_FN_AT_SET   = 6'h01;  // 01
  localparam logic [5:0] FAO_FN_OVER_A   = 6'h02;  // 02
  localparam logic [5:0] FAO_FN_AT_THR_A = 6'h06;  // 06
  localparam logic [5:0] FAO_FN_OVER_B   = 6'h18;  // 24
  localparam logic [5:0] FAO_FN_AT_THR_B = 6'h19;  // 25
  localparam logic [5:0] FAO_FN_ALARM    = 6'h3f;  // alarm function code
  // ***********************************************************
  // hysteresis and sizes
  // ***********************************************************
  localparam int FAO_ON_PCT       = 1;    // turn-on anticipation, percent of max
  localparam int FAO_OFF_PCT      = 2;    // turn-off delay, percent of max
  localparam int FAO_PCT_FULL     = 100;
  localparam int FAO_NUM_OUTS     = 5;
  localparam int FAO_FREQ_W       = 16;
  localparam int FAO_SEL_W        = 6;
  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [FAO_FREQ_W-1:0] FAO_FREQ_RST = 16'h0000;
  localparam logic                  FAO_FLAG_RST = 1'b0;
  localparam logic                  FAO_PIN_RST  = 1'b1;  // active low: released
endpackage

// file: rtl/fao_status_outputs.sv
// status-output logic: run and frequency-arrival functions on five outputs and a relay
`timescale 1ns/10ps
module fao_status_outputs
  import fao_pkg::*;
#(
  parameter int FREQ_W = FAO_FREQ_W,
  parameter int NOUT   = FAO_NUM_OUTS
) (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       ctrl_tick,
  input  wire logic [FREQ_W-1:0]          out_frequency,
  input  wire logic [FREQ_W-1:0]          max_frequency,
  input  wire logic [FREQ_W-1:0]          set_frequency,
  input  wire logic [FREQ_W-1:0]          start_frequency,
  input  wire logic [FREQ_W-1:0]          accel_threshold_a,
  input  wire logic [FREQ_W-1:0]          decel_threshold_a,
  input  wire logic [FREQ_W-1:0]          accel_threshold_b,
  input  wire logic [FREQ_W-1:0]          decel_threshold_b,
  input  wire logic                       alarm_active,
  input  wire logic [NOUT*FAO_SEL_W-1:0]  out_func_sel,
  input  wire logic [FAO_SEL_W-1:0]       relay_func_sel,
  output logic      [NOUT-1:0]            out_pin_n,
  output logic                            relay_on,
  output logic                            at_set_speed_flag,
  output logic                            over_speed_flag_a,
  output logic                            at_threshold_pulse_a,
  output logic                            over_speed_flag_b,
  output logic                            at_threshold_pulse_b,
  output logic                            run_flag
);

  typedef enum logic [1:0] {FAO_DIR_STEADY, FAO_DIR_ACCEL, FAO_DIR_DECEL} fao_dir_t;

  // ***********************************************************
  // helpers
  // ***********************************************************
  // percent of max frequency, widened so the product cannot overflow
  function automatic logic [FREQ_W:0] pct_of(input logic [FREQ_W-1:0] fmax, input int pct);
    logic [FREQ_W+7:0] prod;
    prod   = fmax * pct[7:0];
    pct_of = (FREQ_W+1)'(prod / FAO_PCT_FULL[7:0]);
  endfunction

  // within a band of threshold: [thr - band_lo, thr + band_hi]
  function automatic logic near(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] thr,
                                input logic [FREQ_W:0] band_lo, input logic [FREQ_W:0] band_hi);
    logic [FREQ_W+1:0] fx;
    fx   = {2'b00, f};
    near = (fx + {1'b0, band_lo} >= {2'b00, thr}) && (fx <= {2'b00, thr} + {1'b0, band_hi});
  endfunction

  // map a function code to its flag value
  function automatic logic fn_value(input logic [FAO_SEL_W-1:0] sel,
                                    input logic [5:0] flags, input logic alarm);
    case (sel)
      FAO_FN_RUN:      fn_value = flags[0];
      FAO_FN_AT_SET:   fn_value = flags[1];
      FAO_FN_OVER_A:   fn_value = flags[2];
      FAO_FN_AT_THR_A: fn_value = flags[3];
      FAO_FN_OVER_B:   fn_value = flags[4];
      FAO_FN_AT_THR_B: fn_value = flags[5];
      FAO_FN_ALARM:    fn_value = alarm;
      default:         fn_value = 1'b0;
    endcase
  endfunction

  // ***********************************************************
  // arrival step helpers
  // ***********************************************************
  // over-threshold: set accelerating past the on point, clear decelerating
  // below the off point, otherwise keep; the gap is the hysteresis
  function automatic logic over_step(input logic              cur,
                                     input logic              up,
                                     input logic              dn,
                                     input logic [FREQ_W-1:0] f,
                                     input logic [FREQ_W-1:0] thr_on,
                                     input logic [FREQ_W-1:0] thr_off,
                                     input logic [FREQ_W:0]   band_on,
                                     input logic [FREQ_W:0]   band_off);
    logic [FREQ_W+1:0] fx;
    fx        = {2'b00, f};
    over_step = cur;
    if (up && (fx + {1'b0, band_on} >= {2'b00, thr_on})) begin
      over_step = 1'b1;
    end else if (dn && (fx + {1'b0, band_off} < {2'b00, thr_off})) begin
      over_step = 1'b0;
    end
  endfunction

  // at-threshold: narrow band on approach, widened once on so a hovering
  // frequency cannot chatter; a steady direction gives off
  function automatic logic thr_step(input logic              cur,
                                    input logic              up,
                                    input logic              dn,
                                    input logic [FREQ_W-1:0] f,
                                    input logic [FREQ_W-1:0] thr_up,
                                    input logic [FREQ_W-1:0] thr_dn,
                                    input logic [FREQ_W:0]   band_on,
                                    input logic [FREQ_W:0]   band_off);
    logic [FREQ_W:0] held;
    held     = cur ? band_off : '0;
    thr_step = (up && near(f, thr_up, band_on, held)) ||
               (dn && near(f, thr_dn, held, band_on));
  endfunction

  // ***********************************************************
  // state
  // ***********************************************************
  // one register group per set of related functions keeps each next-state block small
  logic [FREQ_W-1:0] prev_freq_r;
  logic [FREQ_W-1:0] prev_freq_nxt;
  fao_dir_t          dir_r;
  fao_dir_t          dir_nxt;
  logic              run_r;
  logic              run_nxt;
  logic              at_set_r;
  logic              at_set_nxt;
  logic              over_a_r;
  logic              over_a_nxt;
  logic              thr_a_r;
  logic              thr_a_nxt;
  logic              over_b_r;
  logic              over_b_nxt;
  logic              thr_b_r;
  logic              thr_b_nxt;
  logic [5:0]        flags_nxt;
  logic [NOUT-1:0]   pin_fn;
  logic [NOUT-1:0]   pin_n_r;
  logic [NOUT-1:0]   pin_n_nxt;
  logic              relay_r;
  logic              relay_nxt;
  logic              accel;
  logic              decel;

  logic [FREQ_W:0]   on_band;
  logic [FREQ_W:0]   off_band;
  logic [FREQ_W:0]   zero_band;

  // bands follow max frequency, so a new max rescales them at once
  assign on_band   = pct_of(max_frequency, FAO_ON_PCT);
  assign off_band  = pct_of(max_frequency, FAO_OFF_PCT);
  assign zero_band = '0;

  // ***********************************************************
  // direction tracking
  // ***********************************************************
  // steady frequency keeps the last direction so hysteresis holds
  always_comb begin
    prev_freq_nxt = prev_freq_r;
    dir_nxt       = dir_r;
    if (ctrl_tick) begin
      prev_freq_nxt = out_frequency;
      if (out_frequency > prev_freq_r) begin
        dir_nxt = FAO_DIR_ACCEL;
      end else if (out_frequency < prev_freq_r) begin
        dir_nxt = FAO_DIR_DECEL;
      end
    end
  end

  // direction of this update, shared by both threshold pairs; at-set does not use it
  assign accel = (dir_nxt == FAO_DIR_ACCEL);
  assign decel = (dir_nxt == FAO_DIR_DECEL);

  // direction registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prev_freq_r <= FREQ_W'(FAO_FREQ_RST);
      dir_r       <= FAO_DIR_STEADY;
    end else begin
      prev_freq_r <= prev_freq_nxt;
      dir_r       <= dir_nxt;
    end
  end

  // ***********************************************************
  // run and at-set flags
  // ***********************************************************
  // both are evaluated on the control update only, else they stand
  always_comb begin
    run_nxt    = run_r;
    at_set_nxt = at_set_r;
    if (ctrl_tick) begin
      // strict compare: sitting at the start frequency is not yet running
      run_nxt = out_frequency > start_frequency;
      // on 1% early, then held until 2% away on either side
      if (at_set_r) begin
        at_set_nxt = near(out_frequency, set_frequency, off_band, off_band);
      end else begin
        at_set_nxt = near(out_frequency, set_frequency, on_band, zero_band);
      end
    end
  end

  // run and at-set registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_r    <= FAO_FLAG_RST;
      at_set_r <= FAO_FLAG_RST;
    end else begin
      run_r    <= run_nxt;
      at_set_r <= at_set_nxt;
    end
  end

  // ***********************************************************
  // threshold pair flags
  // ***********************************************************
  // pair a and pair b share the step helpers; only the thresholds differ
  always_comb begin
    over_a_nxt = over_a_r;
    thr_a_nxt  = thr_a_r;
    over_b_nxt = over_b_r;
    thr_b_nxt  = thr_b_r;
    if (ctrl_tick) begin
      over_a_nxt = over_step(over_a_r, accel, decel, out_frequency, accel_threshold_a,
                             decel_threshold_a, on_band, off_band);
      thr_a_nxt  = thr_step(thr_a_r, accel, decel, out_frequency, accel_threshold_a,
                            decel_threshold_a, on_band, off_band);
      over_b_nxt = over_step(over_b_r, accel, decel, out_frequency, accel_threshold_b,
                             decel_threshold_b, on_band, off_band);
      thr_b_nxt  = thr_step(thr_b_r, accel, decel, out_frequency, accel_threshold_b,
                            decel_threshold_b, on_band, off_band);
    end
  end

  // threshold pair registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      over_a_r <= FAO_FLAG_RST;
      thr_a_r  <= FAO_FLAG_RST;
      over_b_r <= FAO_FLAG_RST;
      thr_b_r  <= FAO_FLAG_RST;
    end else begin
      over_a_r <= over_a_nxt;
      thr_a_r  <= thr_a_nxt;
      over_b_r <= over_b_nxt;
      thr_b_r  <= thr_b_nxt;
    end
  end

  // bundle in function-code order for the pin selectors
  assign flags_nxt = {thr_b_nxt, over_b_nxt, thr_a_nxt, over_a_nxt, at_set_nxt, run_nxt};

  // ***********************************************************
  // pin and relay mapping
  // ***********************************************************
  // each pin decodes its own code; next flags are used so pins and
  // flags change on the same edge
  for (genvar g = 0; g < NOUT; g++) begin : g_pin
    logic [FAO_SEL_W-1:0] code;
    assign code      = out_func_sel[g*FAO_SEL_W +: FAO_SEL_W];
    assign pin_fn[g] = fn_value(code, flags_nxt, alarm_active);
  end

  // open collector pins: a function that is on pulls its pin low
  always_comb begin
    pin_n_nxt = pin_n_r;
    relay_nxt = relay_r;
    if (ctrl_tick) begin
      pin_n_nxt = ~pin_fn;
      // the relay is not inverted: high energises the coil
      relay_nxt = fn_value(relay_func_sel, flags_nxt, alarm_active);
    end
  end

  // pin and relay registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_n_r <= {NOUT{FAO_PIN_RST}};
      relay_r <= FAO_FLAG_RST;
    end else begin
      pin_n_r <= pin_n_nxt;
      relay_r <= relay_nxt;
    end
  end

  // ***********************************************************
  // outputs, all straight from flops
  // ***********************************************************
  assign out_pin_n            = pin_n_r;
  assign relay_on             = relay_r;
  assign run_flag             = run_r;
  assign at_set_speed_flag    = at_set_r;
  assign over_speed_flag_a    = over_a_r;
  assign at_threshold_pulse_a = thr_a_r;
  assign over_speed_flag_b    = over_b_r;
  assign at_threshold_pulse_b = thr_b_r;

endmodule

// file: sim/fao_status_props.sv
// checker: tick timing and function relations of the status outputs
`timescale 1ns/10ps
module fao_status_props
  import fao_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        ctrl_tick,
  input wire logic [15:0] out_frequency,
  input wire logic [15:0] max_frequency,
  input wire logic [15:0] set_frequency,
  input wire logic [15:0] start_frequency,
  input wire logic [15:0] accel_threshold_a,
  input wire logic [15:0] decel_threshold_a,
  input wire logic        alarm_active,
  input wire logic [29:0] out_func_sel,
  input wire logic [5:0]  relay_func_sel,
  input wire logic [4:0]  out_pin_n,
  input wire logic        relay_on,
  input wire logic        run_flag,
  input wire logic        at_set_speed_flag,
  input wire logic        over_speed_flag_a
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] prev_r;
  logic [16:0] on_b, off_b;
  // last ticked frequency, the only honest reference for direction
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) prev_r <= 16'h0000;
    else if (ctrl_tick) prev_r <= out_frequency;
  // hysteresis bands, truncated like the design
  assign on_b  = 17'(max_frequency / 16'h0064);
  assign off_b = 17'(max_frequency / 16'h0032);
  sequence s_up; ctrl_tick && out_frequency > prev_r; endsequence
  sequence s_down; ctrl_tick && out_frequency < prev_r; endsequence
  // ***********************************************************
  // properties
  // ***********************************************************
  property p_hold;
    !ctrl_tick |=> $stable({out_pin_n, relay_on, run_flag, over_speed_flag_a}); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without tick");
  property p_run;
    ctrl_tick |=> run_flag == ($past(out_frequency) > $past(start_frequency)); endproperty
  a_run: assert property (p_run) else $error("run flag wrong");
  property p_pin_run;
    ctrl_tick && out_func_sel[5:0] == FAO_FN_RUN |=> out_pin_n[0] == !run_flag; endproperty
  a_pin_run: assert property (p_pin_run) else $error("run pin wrong");
  property p_relay;
    ctrl_tick && relay_func_sel == FAO_FN_ALARM |=> relay_on == $past(alarm_active); endproperty
  a_relay: assert property (p_relay) else $error("relay alarm wrong");
  property p_at_set;
    ctrl_tick && out_frequency == set_frequency |=> at_set_speed_flag; endproperty
  a_at_set: assert property (p_at_set) else $error("at set not on");
  property p_over_on;
    s_up ##0 {1'b0, out_frequency} + on_b >= {1'b0, accel_threshold_a} |=> over_speed_flag_a;
  endproperty
  a_over_on: assert property (p_over_on) else $error("over flag not on");
  property p_over_hold;
    s_down ##0 ({1'b0, out_frequency} + off_b >= {1'b0, decel_threshold_a}) ##0
      over_speed_flag_a |=> over_speed_flag_a; endproperty
  a_over_hold: assert property (p_over_hold) else $error("over flag dropped early");
  property p_over_off;
    s_down ##0 {1'b0, out_frequency} + off_b < {1'b0, decel_threshold_a} |=> !over_speed_flag_a;
  endproperty
  a_over_off: assert property (p_over_off) else $error("over flag not off");
endmodule
bind fao_status_outputs fao_status_props u_props (.*);

// file: sim/fao_ext_reader.sv
// partner: external lamps on pulled-up open-collector lines and a relay coil
`timescale 1ns/10ps
module fao_ext_reader (
  input wire logic [4:0] pins_n,
  input wire logic       relay_on,
  output logic     [4:0] lamp_on,
  output logic           coil_on
);
  // a released collector floats to the pull-up, so only a low pin lights
  always_comb lamp_on = ~pins_n;
  always_comb coil_on = relay_on;
endmodule

// file: sim/test_fao_status_outputs.sv
// testbench: run, arrival and relay functions seen through the external reader
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_fao_status_outputs
  import fao_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, ctrl_tick = 1'b0, alarm_active = 1'b0;
  logic [15:0] out_frequency = 16'h0000, max_frequency = 16'h03e8, set_frequency = 16'h01f4;
  logic [15:0] start_frequency = 16'h0032, accel_threshold_a = 16'h012c;
  logic [15:0] decel_threshold_a = 16'h00c8, accel_threshold_b = 16'h0258;
  logic [15:0] decel_threshold_b = 16'h0190;
  logic [29:0] out_func_sel = {FAO_FN_OVER_B, FAO_FN_AT_THR_A, FAO_FN_OVER_A,
                               FAO_FN_AT_SET, FAO_FN_RUN};
  logic [5:0]  relay_func_sel = FAO_FN_AT_THR_B;
  logic [4:0]  out_pin_n, lamp_on;
  logic        relay_on, coil_on, run_flag, at_set_speed_flag, over_speed_flag_a;
  logic        at_threshold_pulse_a, over_speed_flag_b, at_threshold_pulse_b;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  wire [5:0]   fl = {run_flag, at_set_speed_flag, over_speed_flag_a, at_threshold_pulse_a,
                     over_speed_flag_b, at_threshold_pulse_b};
  fao_status_outputs uut (.*);
  fao_ext_reader ext (.pins_n(out_pin_n), .relay_on, .lamp_on, .coil_on);
  always #12.5 ref_clk = ~ref_clk;
  // hang guard: the whole sequence needs well under a hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // tick left high so steps run back to back
  task automatic st(input logic [15:0] f, input logic [5:0] e);
    out_frequency = f;
    ctrl_tick = 1'b1;
    @(negedge ref_clk);
    `CHK("flags", e, fl)
    `CHK("lamps", {e[1], e[2], e[3], e[4], e[5]}, lamp_on)
    `CHK("coil", e[0], coil_on)
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    `CHK("reset pins", 5'h1f, out_pin_n)
    st(16'h0000, 6'h00);
    st(16'h0033, 6'h20);
    st(16'h0032, 6'h00);
    $display("test run indicator done");
    st(16'h0118, 6'h20);
    st(16'h0122, 6'h2c);
    st(16'h013b, 6'h2c);
    st(16'h0141, 6'h28);
    st(16'h01ea, 6'h38);
    st(16'h01f4, 6'h38);
    st(16'h0203, 6'h38);
    st(16'h0209, 6'h28);
    st(16'h024e, 6'h2b);
    st(16'h0195, 6'h2b);
    st(16'h017b, 6'h28);
    st(16'h00cd, 6'h2c);
    st(16'h00b9, 6'h2c);
    st(16'h00b3, 6'h20);
    $display("test arrival ramp done");
    ctrl_tick = 1'b0;
    out_frequency = 16'h0258;
    repeat (3) @(negedge ref_clk);
    `CHK("idle flags", 6'h20, fl)
    relay_func_sel = FAO_FN_ALARM;
    out_func_sel = {5{6'h05}};
    alarm_active = 1'b1;
    // alarm up then down while pair b turns on and holds: only the relay follows it
    ctrl_tick = 1'b1;
    @(negedge ref_clk);
    `CHK("alarm flags", 6'h2b, fl)
    `CHK("alarm coil", 1'b1, coil_on)
    `CHK("unknown code lamps", 5'h00, lamp_on)
    alarm_active = 1'b0;
    @(negedge ref_clk);
    `CHK("steady flags", 6'h2b, fl)
    `CHK("alarm off coil", 1'b0, coil_on)
    ctrl_tick = 1'b0;
    $display("test relay and codes done");
    test_done();
  end
endmodule
